//--- usu_pkg.sv
// Purpose: Shared constants and carriers for the universal serial shift unit.
// Assumes: One system clock; the serial clock pin is a second clock domain.
// Notes:   Control and status travel as packed structs on plain ports.
package usu_pkg;

  // ----------------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------------
  localparam int          SHIFT_W     = 8;
  localparam int          CNT_W       = 4;
  localparam logic [7:0]  SHIFT_RESET = 8'h00;
  localparam logic [3:0]  CNT_RESET   = 4'h0;
  localparam logic [3:0]  CNT_MAX     = 4'hF;
  localparam logic [4:0]  CNT_CARRY   = 5'h10;

  // ----------------------------------------------------------------------
  // Wire modes
  // ----------------------------------------------------------------------
  localparam logic [1:0]  WM_NONE     = 2'h0;
  localparam logic [1:0]  WM_THREE    = 2'h1;
  localparam logic [1:0]  WM_TWO      = 2'h2;
  localparam logic [1:0]  WM_TWO_HOLD = 2'h3;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       start_int_en;
    logic       ovf_int_en;
    logic [1:0] wire_mode;
    logic       external_clock_select;
    logic       clock_edge_select;
    logic       software_clock_strobe;
    logic       clock_toggle_bit;
  } usu_ctrl_t;

  typedef struct packed {
    logic       start_flag;
    logic       counter_overflow_flag;
    logic [3:0] count;
  } usu_status_t;

  typedef struct packed {
    usu_ctrl_t  ctrl;
    logic [7:0] shreg;
    logic [3:0] cnt;
    logic       ovf;
    logic       stf;
    logic       samp;
    logic       latch;
    logic       sck_out;
    logic       sck_pin_out;
    logic       sck_oe_n;
    logic       do_out;
    logic       sda_out;
    logic       sda_oe_n;
    logic       ovf_irq;
    logic       start_irq;
    logic       di_s1;
    logic       di_s2;
    logic       di_d;
    logic       sck_s1;
    logic       sck_s2;
    logic       rt_s1;
    logic       rt_s2;
    logic       rt_s3;
    logic       ft_s1;
    logic       ft_s2;
    logic       ft_s3;
  } usu_state_t;

endpackage

//--- usu_core.sv
// Purpose: Universal serial shift unit: shift register, output latch,
//          4-bit edge counter, three-wire and two-wire pin handling.
// Assumes: Software pulses ctrl_wr, status_wr and data_wr for one clock.
//          Each serial clock half period lasts at least four system clocks.
// Notes:   The pin clock domain only captures data in and flips toggles.
`timescale 1ns/1ps

// What this block does
// - Eight-bit shift register, MSB drives mode-chosen pin
// - No receive buffer; next shift overwrites data
// - Output latch moves data opposite the sample edge
// - Serial input always taken from the input pin
// - Readable writable 4-bit counter with overflow flag
// - Counter and shifter advance on same clock
// - External clock counts both rising and falling edges
// - Clock from pin, timer match or strobe
// - Two-wire start condition raises an interrupt
// - Two-wire holds clock low after start; WM_TWO_HOLD also after overflow
// - Three-wire mode matches SPI modes 0 and 1
// - Master and slave swap bytes after eight clocks
// - Master clock toggles by port bit or control bit
// - Edge select picks sampling and shifting edges
// - Sixteen counted edges overflow and flag the byte
// - Overflow interrupt can wake from idle sleep
// - Status write of one clears flag, loads counter
// - External plus strobe counts toggles driving clock pin
// - Alternating control writes run master at half rate
// - Low strobe bit with external clock selects slave
// - Data write in a shift cycle wins
// - Latch open first half cycle, always when internal
module usu_core (
  input  wire logic               clock,
  input  wire logic               arst_n,
  input  wire logic               serial_clock_pin,
  input  wire logic               serial_input_pin,
  input  wire logic               timer_match,
  input  wire logic               port_toggle,
  input  wire logic               sck_drive_en,
  input  wire logic               ctrl_wr,
  input  wire usu_pkg::usu_ctrl_t ctrl_wdata,
  input  wire logic               status_wr,
  input  wire usu_pkg::usu_status_t status_wdata,
  input  wire logic               data_wr,
  input  wire logic [7:0]         data_wdata,
  output logic [7:0]              serial_shift_register,
  output usu_pkg::usu_status_t    serial_status_register,
  output usu_pkg::usu_ctrl_t      serial_control_register,
  output logic                    serial_clock_out,
  output logic                    serial_clock_oe_n,
  output logic                    serial_data_out,
  output logic                    sda_out,
  output logic                    sda_oe_n,
  output logic                    ovf_irq,
  output logic                    start_irq
);

  // ----------------------------------------------------------------------
  // Pin clock domain
  // ----------------------------------------------------------------------
  // Each edge captures the input pin and flips a toggle; the system side
  // reads the captured bit only after the toggle has crossed, so it is
  // stable by then.
  logic link_rise_tgl;
  logic link_rise_bit;
  logic link_fall_tgl;
  logic link_fall_bit;

  always_ff @(posedge serial_clock_pin or negedge arst_n) begin
    if (!arst_n) begin
      link_rise_tgl <= 1'b0;
      link_rise_bit <= 1'b0;
    end else begin
      link_rise_tgl <= ~link_rise_tgl;
      link_rise_bit <= serial_input_pin;
    end
  end

  always_ff @(negedge serial_clock_pin or negedge arst_n) begin
    if (!arst_n) begin
      link_fall_tgl <= 1'b0;
      link_fall_bit <= 1'b0;
    end else begin
      link_fall_tgl <= ~link_fall_tgl;
      link_fall_bit <= serial_input_pin;
    end
  end

  // ----------------------------------------------------------------------
  // System clock domain
  // ----------------------------------------------------------------------
  usu_pkg::usu_state_t q;
  usu_pkg::usu_state_t next_q;

  logic       rise_evt;
  logic       fall_evt;
  logic       tog;
  logic       ext;
  logic       strobe_sel;
  logic       edge_sel;
  logic       two_wire;
  logic       do_sample;
  logic       do_shift;
  logic       sample_bit;
  logic       shift_bit;
  logic [1:0] cnt_inc;
  logic [4:0] cnt_sum;
  logic       ovf_evt;
  logic       start_evt;
  logic       sck_lvl;
  logic       hold;

  always_comb begin
    next_q = q;
    next_q.di_s1  = serial_input_pin;
    next_q.di_s2  = q.di_s1;
    next_q.di_d   = q.di_s2;
    next_q.sck_s1 = serial_clock_pin;
    next_q.sck_s2 = q.sck_s1;
    next_q.rt_s1  = link_rise_tgl;
    next_q.rt_s2  = q.rt_s1;
    next_q.rt_s3  = q.rt_s2;
    next_q.ft_s1  = link_fall_tgl;
    next_q.ft_s2  = q.ft_s1;
    next_q.ft_s3  = q.ft_s2;
    rise_evt = q.rt_s2 ^ q.rt_s3;
    fall_evt = q.ft_s2 ^ q.ft_s3;

    // Strobe bits are actions; only the counter-source select is kept
    if (ctrl_wr) begin
      next_q.ctrl = ctrl_wdata;
      next_q.ctrl.software_clock_strobe = ctrl_wdata.external_clock_select
                                        & ctrl_wdata.software_clock_strobe;
      next_q.ctrl.clock_toggle_bit = 1'b0;
    end
    ext        = next_q.ctrl.external_clock_select;
    strobe_sel = next_q.ctrl.software_clock_strobe;
    edge_sel   = next_q.ctrl.clock_edge_select;
    two_wire   = next_q.ctrl.wire_mode[1];

    tog = (ctrl_wr & ctrl_wdata.clock_toggle_bit) | port_toggle;
    if (tog) begin
      next_q.sck_out = ~q.sck_out;
    end

    do_sample  = 1'b0;
    do_shift   = 1'b0;
    sample_bit = q.samp;
    shift_bit  = q.samp;
    cnt_inc    = 2'h0;
    if (ext && strobe_sel) begin
      // Master: the toggle drives the pin and is itself the counted edge
      cnt_inc    = {1'b0, tog};
      sample_bit = q.di_s2;
      do_sample  = tog & (~q.sck_out ^ edge_sel);
      do_shift   = tog & ~(~q.sck_out ^ edge_sel);
    end else if (ext) begin
      cnt_inc = {1'b0, rise_evt} + {1'b0, fall_evt};
      if (edge_sel) begin
        sample_bit = link_fall_bit;
        do_sample  = fall_evt;
        do_shift   = rise_evt;
      end else begin
        sample_bit = link_rise_bit;
        do_sample  = rise_evt;
        do_shift   = fall_evt;
      end
    end else begin
      // Internal sources sample and shift in one step
      do_shift  = edge_sel ? timer_match
                           : (ctrl_wr & ctrl_wdata.software_clock_strobe);
      shift_bit = q.di_s2;
      cnt_inc   = {1'b0, do_shift};
    end

    if (do_sample) begin
      next_q.samp = sample_bit;
    end
    // A write in the same cycle as a shift keeps the written byte
    if (data_wr) begin
      next_q.shreg = data_wdata;
    end else if (do_shift) begin
      next_q.shreg = {q.shreg[6:0], shift_bit};
    end

    cnt_sum = {1'b0, q.cnt} + {3'h0, cnt_inc};
    ovf_evt = cnt_sum[4];
    if (status_wr) begin
      next_q.cnt = status_wdata.count;
    end else begin
      next_q.cnt = cnt_sum[3:0];
    end
    if (status_wr && status_wdata.counter_overflow_flag) begin
      next_q.ovf = 1'b0;
    end
    if (ovf_evt) begin
      next_q.ovf = 1'b1;
    end

    // Start: data falls while the clock line is high
    start_evt = two_wire & q.di_d & ~q.di_s2 & q.sck_s2;
    if (status_wr && status_wdata.start_flag) begin
      next_q.stf = 1'b0;
    end
    if (start_evt) begin
      next_q.stf = 1'b1;
    end

    // Latch open in the first half cycle, where the shift edge lands
    sck_lvl = strobe_sel ? next_q.sck_out : q.sck_s2;
    if (!ext || (sck_lvl == edge_sel)) begin
      next_q.latch = next_q.shreg[7];
    end

    next_q.do_out   = (next_q.ctrl.wire_mode == usu_pkg::WM_THREE) & next_q.latch;
    next_q.sda_out  = 1'b0;
    next_q.sda_oe_n = ~(two_wire & ~next_q.latch);

    hold = two_wire & (next_q.stf | ((next_q.ctrl.wire_mode == usu_pkg::WM_TWO_HOLD)
                                     & next_q.ovf));
    next_q.sck_oe_n    = ~(sck_drive_en | hold);
    next_q.sck_pin_out = next_q.sck_out & ~hold;

    next_q.ovf_irq   = next_q.ovf & next_q.ctrl.ovf_int_en;
    next_q.start_irq = next_q.stf & next_q.ctrl.start_int_en;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q          <= '0;
      q.shreg    <= usu_pkg::SHIFT_RESET;
      q.cnt      <= usu_pkg::CNT_RESET;
      q.sck_oe_n <= 1'b1;
      q.sda_oe_n <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign serial_shift_register                       = q.shreg;
  assign serial_status_register                       = {q.stf, q.ovf, q.cnt};
  assign serial_control_register                      = q.ctrl;
  assign serial_clock_out                             = q.sck_pin_out;
  assign serial_clock_oe_n                            = q.sck_oe_n;
  assign serial_data_out                              = q.do_out;
  assign sda_out                                      = q.sda_out;
  assign sda_oe_n                                     = q.sda_oe_n;
  assign ovf_irq                                      = q.ovf_irq;
  assign start_irq                                    = q.start_irq;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence last_count_s;
    (q.cnt == usu_pkg::CNT_MAX) && (cnt_inc == 2'h1) && !status_wr;
  endsequence

  sequence slave_rise_s;
    q.ctrl.external_clock_select && !q.ctrl.software_clock_strobe && !ctrl_wr
      && rise_evt && !fall_evt && !status_wr;
  endsequence

  counter_wrap_a: assert property (last_count_s |=> (q.cnt == 4'h0) && q.ovf)
    else $error("counter did not wrap to zero with flag");

  byte_done_a: assert property (
    (q.cnt == 4'h0) && !q.ovf ##1 (cnt_inc == 2'h1 && !status_wr) [*8]
    |-> !q.ovf)
    else $error("overflow flag set before sixteen edges");

  write_wins_a: assert property (data_wr |=> q.shreg == $past(data_wdata))
    else $error("data write lost to shift");

  status_clear_a: assert property (
    status_wr && status_wdata.counter_overflow_flag && (status_wdata.count == 4'h0)
      && !ovf_evt |=> !q.ovf && (q.cnt == 4'h0))
    else $error("status write did not clear flag and counter");

  edge_count_a: assert property (slave_rise_s |=> q.cnt == $past(q.cnt) + 4'h1)
    else $error("external edge not counted");

  input_sample_a: assert property (
    slave_rise_s and !q.ctrl.clock_edge_select |=> q.samp == $past(link_rise_bit))
    else $error("rising edge did not sample input pin");

  latch_open_a: assert property (
    (q.ctrl.wire_mode == usu_pkg::WM_THREE) && !q.ctrl.external_clock_select && !ctrl_wr
      |=> serial_data_out == q.shreg[7])
    else $error("internal clock latch not transparent");

  toggle_pin_a: assert property (
    ctrl_wr && ctrl_wdata.clock_toggle_bit |=> q.sck_out != $past(q.sck_out))
    else $error("clock toggle bit did not toggle the clock");

  start_hold_a: assert property (start_evt |=> q.stf && !serial_clock_oe_n)
    else $error("start condition did not hold the clock low");

  start_irq_a: assert property (
    start_evt && q.ctrl.start_int_en && !ctrl_wr ##1 !ctrl_wr |=> start_irq)
    else $error("start condition did not raise interrupt");

endmodule

//--- usu_spi_far.sv
// Purpose: Far-side SPI master model for the serial shift unit bench.
// Assumes: Device sits in three-wire slave mode; link_clk paces each half cell.
// Notes:   Clock idles low between frames; released data shows the inverse level.
`timescale 1ns/1ps
module usu_spi_far (
  input  wire logic       link_clk,
  input  wire logic       start,
  input  wire logic       mode1,
  input  wire logic [7:0] tx_byte,
  input  wire logic       miso,
  output logic            sck,
  output logic            mosi,
  output logic [7:0]      rx_byte,
  output logic            done
);
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    rx_byte = 8'h00;
    done = 1'b0;
  end

  // Half cells of 36 ns leave the device room to resync each edge
  always begin
    wait (start);
    for (int i = 7; i >= 0; i--) begin
      if (!mode1) mosi = tx_byte[i];
      repeat (6) @(posedge link_clk);
      sck = 1'b1;
      if (mode1) mosi = tx_byte[i];
      else rx_byte = {rx_byte[6:0], miso};
      repeat (6) @(posedge link_clk);
      sck = 1'b0;
      if (mode1) rx_byte = {rx_byte[6:0], miso};
    end
    repeat (6) @(posedge link_clk);
    mosi = ~mosi;
    done = 1'b1;
    wait (!start);
    done = 1'b0;
  end
endmodule

//--- test_universal_serial_shift_unit.sv
// Purpose: Self-checking bench for the universal serial shift unit.
// Assumes: Software writes are one-cycle strobes; far side is a mode 0/1 master.
// Notes:   Master and internal runs loop data out back to data in.
`timescale 1ns/1ps
module test_universal_serial_shift_unit;
  logic                 clock;
  logic                 link_clk;
  logic                 arst_n;
  logic                 timer_match;
  logic                 port_toggle;
  logic                 sck_drive_en;
  logic                 ctrl_wr;
  logic                 status_wr;
  logic                 data_wr;
  logic                 loop_en;
  logic                 far_start;
  logic                 far_mode1;
  logic                 far_sck;
  logic                 far_mosi;
  logic                 far_done;
  logic [7:0]           far_tx;
  logic [7:0]           far_rx;
  logic [7:0]           data_wdata;
  usu_pkg::usu_ctrl_t   ctrl_wdata;
  usu_pkg::usu_status_t status_wdata;
  logic [7:0]           serial_shift_register;
  usu_pkg::usu_status_t serial_status_register;
  usu_pkg::usu_ctrl_t   serial_control_register;
  logic                 serial_clock_out;
  logic                 serial_clock_oe_n;
  logic                 serial_data_out;
  logic                 sda_oe_n;
  logic                 ovf_irq;
  logic                 start_irq;
  logic                 sck_wire;
  logic                 din_wire;
  int                   fail_count;
  int                   checks_done;
  int                   cycles;

  // Clock pin is two-way: whoever drives it sets the level seen by both
  assign sck_wire = serial_clock_oe_n ? far_sck : serial_clock_out;
  assign din_wire = loop_en ? serial_data_out : far_mosi;

  always #2 clock = ~clock;
  initial begin
    link_clk = 1'b0;
    #0.7;
    forever #3 link_clk = ~link_clk;
  end

  usu_core i_usu_core (
    .clock                   (clock),
    .arst_n                  (arst_n),
    .serial_clock_pin        (sck_wire),
    .serial_input_pin        (din_wire),
    .timer_match             (timer_match),
    .port_toggle             (port_toggle),
    .sck_drive_en            (sck_drive_en),
    .ctrl_wr                 (ctrl_wr),
    .ctrl_wdata              (ctrl_wdata),
    .status_wr               (status_wr),
    .status_wdata            (status_wdata),
    .data_wr                 (data_wr),
    .data_wdata              (data_wdata),
    .serial_shift_register   (serial_shift_register),
    .serial_status_register  (serial_status_register),
    .serial_control_register (serial_control_register),
    .serial_clock_out        (serial_clock_out),
    .serial_clock_oe_n       (serial_clock_oe_n),
    .serial_data_out         (serial_data_out),
    .sda_out                 (),
    .sda_oe_n                (sda_oe_n),
    .ovf_irq                 (ovf_irq),
    .start_irq               (start_irq)
  );

  usu_spi_far i_usu_spi_far (
    .link_clk (link_clk),
    .start    (far_start),
    .mode1    (far_mode1),
    .tx_byte  (far_tx),
    .miso     (serial_data_out),
    .sck      (far_sck),
    .mosi     (far_mosi),
    .rx_byte  (far_rx),
    .done     (far_done)
  );

  task automatic wrap_up;
    if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Kinds: 0 control, 1 status, 2 data, 3 data with timer, 4 port toggle, 5 timer
  task automatic wr(input int sel, input logic [7:0] v);
    @(posedge clock);
    ctrl_wr <= (sel == 0);
    status_wr <= (sel == 1);
    data_wr <= (sel == 2 || sel == 3);
    timer_match <= (sel == 3 || sel == 5);
    port_toggle <= (sel == 4);
    ctrl_wdata <= v;
    status_wdata <= v[5:0];
    data_wdata <= v;
    @(posedge clock);
    {ctrl_wr, status_wr, data_wr, timer_match, port_toggle} <= 5'h00;
    repeat (4) @(posedge clock);
    #1;
  endtask

  task automatic frame(input logic m1, input logic [7:0] tx);
    int n;
    n = 0;
    @(posedge clock);
    far_mode1 <= m1;
    far_tx <= tx;
    far_start <= 1'b1;
    while (far_done !== 1'b1 && n < 400) begin
      @(posedge clock);
      n++;
    end
    far_start <= 1'b0;
    if (far_done !== 1'b1) begin
      fail_count++;
      $display("ERROR %0t far side frame timed out", $time);
    end
    repeat (8) @(posedge clock);
    #1;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      wrap_up();
    end
  end

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    arst_n = 1'b0;
    {timer_match, port_toggle, sck_drive_en, ctrl_wr, status_wr} = 5'h00;
    {data_wr, loop_en, far_start, far_mode1} = 4'h0;
    {ctrl_wdata, status_wdata, data_wdata, far_tx} = 30'h0;
    fail_count = 0;
    checks_done = 0;
    cycles = 0;
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    chk(serial_shift_register, 8'h00);
    chk({2'h0, serial_status_register}, 8'h00);
    chk(serial_control_register, 8'h00);
    chk({6'h00, serial_clock_oe_n, sda_oe_n}, 8'h03);
    wr(0, 8'h58);
    chk(serial_control_register, 8'h58);
    wr(1, 8'h10);
    wr(2, 8'hC3);
    chk(serial_shift_register, 8'hC3);
    chk({7'h00, serial_data_out}, 8'h01);
    frame(1'b0, 8'h5A);
    chk(serial_shift_register, 8'h5A);
    chk(far_rx, 8'hC3);
    chk({2'h0, serial_status_register}, 8'h10);
    chk({7'h00, ovf_irq}, 8'h01);
    wr(1, 8'h18);
    chk({2'h0, serial_status_register}, 8'h08);
    chk({7'h00, ovf_irq}, 8'h00);
    wr(0, 8'h5C);
    frame(1'b1, 8'h96);
    chk({2'h0, serial_status_register}, 8'h18);
    // Master run: loopback makes the byte rotate back to itself
    wr(1, 8'h10);
    wr(2, 8'hB4);
    @(posedge clock);
    loop_en <= 1'b1;
    sck_drive_en <= 1'b1;
    wr(0, 8'h1A);
    chk(serial_control_register, 8'h1A);
    chk({7'h00, serial_clock_oe_n}, 8'h00);
    for (int i = 0; i < 16; i++) begin
      wr((i == 0) ? 4 : 0, 8'h1B);
      chk({7'h00, serial_clock_out}, {7'h00, ~i[0]});
    end
    chk(serial_shift_register, 8'hB4);
    chk({2'h0, serial_status_register}, 8'h10);
    @(posedge clock);
    sck_drive_en <= 1'b0;
    wr(0, 8'h14);
    wr(1, 8'h10);
    wr(2, 8'h81);
    wr(5, 8'h00);
    chk(serial_shift_register, 8'h03);
    chk({2'h0, serial_status_register}, 8'h01);
    wr(0, 8'h12);
    chk(serial_shift_register, 8'h06);
    wr(0, 8'h14);
    wr(3, 8'h3C);
    chk(serial_shift_register, 8'h3C);
    // Two-wire start: data falls while the driven clock is high
    wr(2, 8'hFF);
    @(posedge clock);
    sck_drive_en <= 1'b1;
    wr(4, 8'h00);
    wr(0, 8'hA4);
    chk({2'h0, serial_status_register}, 8'h23);
    chk({7'h00, start_irq}, 8'h01);
    chk({6'h00, serial_clock_oe_n, serial_clock_out}, 8'h00);
    wr(1, 8'h20);
    chk({7'h00, serial_clock_out}, 8'h01);
    chk({7'h00, start_irq}, 8'h00);
    wrap_up();
  end
endmodule
